/* File: rtl/tsense_master.sv */
// bus master end issuing register reads and writes over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module tsense_master
    import tsense_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    tsense_link_if.master    link,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic        cmd_set_ptr,
    input  wire logic [2:0]  cmd_dev,
    input  wire logic [7:0]  cmd_ptr,
    input  wire logic [1:0]  cmd_nbytes,
    input  wire logic [15:0] cmd_wdata,
    output logic             rsp_valid,
    input  wire logic        rsp_ready,
    output logic [7:0]       rsp_data,
    output logic             rsp_nack
);
    typedef enum logic [2:0] {
        MS_IDLE  = 3'b000,
        MS_START = 3'b001,
        MS_BYTE  = 3'b010,
        MS_STOP  = 3'b011,
        MS_RSTRT = 3'b100
    } mst_state_e;

    mst_state_e state_reg;
    logic [1:0] sda_sync_reg;
    logic [7:0] div_reg;
    logic       tick;
    logic [1:0] phase_reg;
    logic [3:0] bit_reg;
    logic [7:0] tx_reg, rx_reg;
    logic [2:0] byte_idx_reg;
    logic [2:0] byte_tot_reg;
    logic       rd_reg, rd_phase_reg, nack_reg, scl_reg, sda_reg;
    logic [7:0] dev_reg, ptr_reg;
    logic [15:0] wd_reg;
    logic [1:0] nb_reg;
    // two-entry response buffer
    logic [8:0] buf_mem [0:1];
    logic       wr_ptr_reg, rd_ptr_reg;
    logic [1:0] count_reg;
    logic       push, buf_ready;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sda_sync_reg <= 2'b11;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
        end
    end

    // quarter-bit enable divider; stalls while buffer cannot take a byte
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_reg <= 8'h00;
        end else if (div_reg == 8'(SCL_HALF_CYCLES - 1)) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end
    assign tick      = (div_reg == 8'(SCL_HALF_CYCLES - 1)) && buf_ready;
    assign buf_ready = (count_reg != 2'h2);
    assign cmd_ready = (state_reg == MS_IDLE);

    function automatic logic [7:0] next_byte(input logic [2:0] idx, input logic rd, input logic sp,
                                             input logic [7:0] dv, input logic [7:0] pt, input logic [15:0] wd);
        if (idx == 3'h0) begin
            next_byte = {dv[7:1], rd & ~sp};
        end else if (idx == 3'h1) begin
            next_byte = pt;
        end else if (idx == 3'h2) begin
            next_byte = wd[15:8];
        end else begin
            next_byte = wd[7:0];
        end
    endfunction

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= MS_IDLE;
            phase_reg    <= 2'h0;
            bit_reg      <= 4'h0;
            tx_reg       <= 8'h00;
            rx_reg       <= 8'h00;
            byte_idx_reg <= 3'h0;
            byte_tot_reg <= 3'h0;
            rd_reg       <= 1'b0;
            rd_phase_reg <= 1'b0;
            nack_reg     <= 1'b0;
            scl_reg      <= 1'b1;
            sda_reg      <= 1'b1;
            dev_reg      <= 8'h00;
            ptr_reg      <= 8'h00;
            wd_reg       <= 16'h0000;
            nb_reg       <= 2'h0;
            push         <= 1'b0;
        end else begin
            push <= 1'b0;
            case (state_reg)
                MS_IDLE: begin
                    scl_reg <= 1'b1;
                    sda_reg <= 1'b1;
                    if (cmd_valid) begin
                        dev_reg      <= {DEV_ADDR_HIGH, cmd_dev, 1'b0};
                        ptr_reg      <= cmd_ptr;
                        wd_reg       <= cmd_wdata;
                        nb_reg       <= cmd_nbytes;
                        rd_reg       <= cmd_read;
                        rd_phase_reg <= cmd_read & ~cmd_set_ptr;
                        byte_idx_reg <= 3'h0;
                        // write: addr+ptr+data; read with pointer set: addr+ptr then restart
                        byte_tot_reg <= cmd_read ? (cmd_set_ptr ? 3'h2 : 3'(cmd_nbytes) + 3'h1)
                                                 : 3'(cmd_nbytes) + 3'h2;
                        tx_reg       <= {DEV_ADDR_HIGH, cmd_dev, cmd_read & ~cmd_set_ptr};
                        phase_reg    <= 2'h0;
                        state_reg    <= MS_START;
                    end
                end
                MS_START: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        sda_reg <= 1'b0;
                    end else if (phase_reg == 2'h1) begin
                        scl_reg   <= 1'b0;
                        bit_reg   <= 4'h0;
                        phase_reg <= 2'h0;
                        state_reg <= MS_BYTE;
                    end
                end
                MS_BYTE: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        if (bit_reg < ACK_SLOT) begin
                            sda_reg <= (rd_phase_reg && byte_idx_reg != 3'h0) ? 1'b1 : tx_reg[7];
                        end else begin
                            // ack our received bytes except the last
                            sda_reg <= !(rd_phase_reg && byte_idx_reg != 3'h0 &&
                                         byte_idx_reg + 3'h1 != byte_tot_reg);
                        end
                    end else if (phase_reg == 2'h1) begin
                        scl_reg <= 1'b1;
                    end else if (phase_reg == 2'h2) begin
                        if (bit_reg < ACK_SLOT) begin
                            rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
                        end else begin
                            nack_reg <= sda_sync_reg[1];
                        end
                    end else begin
                        scl_reg <= 1'b0;
                        tx_reg  <= {tx_reg[6:0], 1'b1};
                        bit_reg <= bit_reg + 4'h1;
                        if (bit_reg == ACK_SLOT) begin
                            bit_reg      <= 4'h0;
                            byte_idx_reg <= byte_idx_reg + 3'h1;
                            tx_reg       <= next_byte(byte_idx_reg + 3'h1, rd_reg, 1'b0, dev_reg, ptr_reg, wd_reg);
                            if (rd_phase_reg && byte_idx_reg != 3'h0) begin
                                push <= 1'b1;
                            end
                            if (byte_idx_reg + 3'h1 == byte_tot_reg || (!rd_phase_reg && nack_reg)) begin
                                state_reg <= (rd_reg && !rd_phase_reg && !nack_reg) ? MS_RSTRT : MS_STOP;
                            end
                        end
                    end
                end
                MS_RSTRT: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        sda_reg <= 1'b1;
                    end else if (phase_reg == 2'h1) begin
                        scl_reg <= 1'b1;
                    end else if (phase_reg == 2'h2) begin
                        rd_phase_reg <= 1'b1;
                        byte_idx_reg <= 3'h0;
                        byte_tot_reg <= 3'(nb_reg) + 3'h1;
                        tx_reg       <= {dev_reg[7:1], 1'b1};
                        phase_reg    <= 2'h0;
                        state_reg    <= MS_START;
                    end
                end
                MS_STOP: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    if (phase_reg == 2'h0) begin
                        sda_reg <= 1'b0;
                    end else if (phase_reg == 2'h1) begin
                        scl_reg <= 1'b1;
                    end else if (phase_reg == 2'h2) begin
                        sda_reg   <= 1'b1;
                        state_reg <= MS_IDLE;
                    end
                end
                default: state_reg <= MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (rsp_valid && rsp_ready) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + 2'(push) - 2'(rsp_valid && rsp_ready);
        end
    end
    always_ff @(posedge core_clk) begin
        if (push) begin
            buf_mem[wr_ptr_reg] <= {1'b0, rx_reg};
        end
    end
    assign rsp_valid = (count_reg != 2'h0);
    assign rsp_data  = buf_mem[rd_ptr_reg][7:0];
    assign rsp_nack  = nack_reg;

    assign link.scl_out   = 1'b0;
    assign link.scl_oe    = ~scl_reg;
    assign link.sda_m_out = 1'b0;
    assign link.sda_m_oe  = ~sda_reg;
endmodule
`default_nettype wire

/* File: rtl/tsense_pkg.sv */
// shared constants for the two-wire temperature sensor link
package tsense_pkg;
    localparam logic [3:0]  DEV_ADDR_HIGH    = 4'h9;
    localparam int          CORE_CLK_HZ      = 40000000;
    localparam int          TIMEOUT_MIN_MS   = 75;
    localparam int          TIMEOUT_MAX_MS   = 325;
    // least time rounds up: 75 ms at 40 MHz
    localparam int          TIMEOUT_CYCLES   = (CORE_CLK_HZ / 1000) * TIMEOUT_MIN_MS;
    localparam int          SCL_HALF_CYCLES  = 4;
    localparam logic [1:0]  PTR_TEMP         = 2'h0;
    localparam logic [1:0]  PTR_CONF         = 2'h1;
    localparam logic [1:0]  PTR_HYST         = 2'h2;
    localparam logic [1:0]  PTR_OVER         = 2'h3;
    localparam logic [5:0]  PTR_UPPER_ZERO   = 6'h00;
    localparam logic [7:0]  PTR_RESET        = 8'h00;
    localparam logic [15:0] CONF_RESET       = 16'h0000;
    localparam logic [15:0] HYST_RESET       = 16'h4B00;
    localparam logic [15:0] OVER_RESET       = 16'h5000;
    localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;
    localparam logic [3:0]  ACK_SLOT         = 4'h8;
endpackage

/* File: rtl/tsense_link_if.sv */
// two-wire link between bus master and sensor slave
`timescale 1ns/1ps
`default_nettype none
interface tsense_link_if;
    logic scl_out;
    logic scl_oe;
    logic sda_m_out;
    logic sda_m_oe;
    logic sda_s_out;
    logic sda_s_oe;
    // open-drain wired-and with pull-ups
    wire  scl = scl_oe ? scl_out : 1'b1;
    wire  sda = (sda_m_oe ? sda_m_out : 1'b1) & (sda_s_oe ? sda_s_out : 1'b1);
    modport master (output scl_out, output scl_oe, output sda_m_out, output sda_m_oe, input scl, input sda);
    modport slave  (output sda_s_out, output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire

/* File: rtl/tsense_slave.sv */
// sensor-side two-wire slave with pointer and register file
// Notes on behaviour
// [R1] master drives clock; slave sends and receives
// [R2] eight data bits then acknowledge clock
// [R3] answer only address 1001 plus straps
// [R4] master must read whole sixteen-bit words
// [R5] start only while bus is idle
// [R6] sda change with scl high is control
// [R7] start is sda fall, scl high
// [R8] stop is sda rise, scl high
// [R9] data changes low, sampled on high
// [R10] start opens, stop closes, unlimited bytes
// [R11] acknowledger holds sda low whole high
// [R12] addressed slave acknowledges every received byte; code leaves a pointer byte with nonzero upper bits unacked
// [R13] master nacks last read byte, slave releases
// [R14] first byte after write address is pointer
// [R15] read from stored or freshly written pointer
// [R16] config reads one byte, others two
// [R17] pointer persists, resets to temperature
// [R18] pointer upper bits nonzero abort operation
// [R19] sda low past timeout resets interface
// [R20] words high byte first; config writes one byte
// [R21] repeated start restarts address, keeps pointer
`timescale 1ns/1ps
`default_nettype none
module tsense_slave
    import tsense_pkg::*;
#(
    parameter int TIMEOUT_CNT = TIMEOUT_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    tsense_link_if.slave     link,
    input  wire logic        addr_select_pin_2,
    input  wire logic        addr_select_pin_1,
    input  wire logic        addr_select_pin_0,
    input  wire logic [15:0] temp_value,
    output logic [7:0]       conf_value,
    output logic [15:0]      hyst_value,
    output logic [15:0]      over_value,
    output logic [7:0]       pointer_value,
    output logic             busy
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_PTR   = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_IGN   = 3'b101
    } slv_state_e;

    logic [1:0] scl_sync_reg, sda_sync_reg;
    logic       scl_d_reg, sda_d_reg;
    logic       scl_rise, scl_fall, start_cond, stop_cond;
    slv_state_e state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic       ack_phase_reg, rd_nack_reg, rd_second_reg, wr_second_reg;
    logic [7:0] tx_reg;
    logic       sda_low_reg;
    logic [5:0] strap_sync_reg;
    logic [31:0] to_cnt_reg;
    logic       timeout;
    logic [15:0] cur_word;

    // two-stage synchronisers for the link pins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
            strap_sync_reg <= 6'h00;
        end else begin
            strap_sync_reg <= {strap_sync_reg[2:0], addr_select_pin_2, addr_select_pin_1, addr_select_pin_0};
            scl_sync_reg <= {scl_sync_reg[0], link.scl};
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end

    assign scl_rise   = scl_sync_reg[1] & ~scl_d_reg;   // [R9]
    assign scl_fall   = ~scl_sync_reg[1] & scl_d_reg;
    assign start_cond = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];  // [R6] [R7]
    assign stop_cond  = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];  // [R8]

    // bus timeout counter on a held-low data line
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            to_cnt_reg <= 32'h0000_0000;
        end else if (sda_sync_reg[1]) begin
            to_cnt_reg <= 32'h0000_0000;
        end else if (!timeout) begin
            to_cnt_reg <= to_cnt_reg + 32'h0000_0001;
        end
    end
    assign timeout = (to_cnt_reg >= 32'(TIMEOUT_CNT));  // [R19]

    function automatic logic [15:0] reg_word(input logic [1:0] sel, input logic [15:0] t,
                                             input logic [7:0] c, input logic [15:0] h, input logic [15:0] o);
        if (sel == PTR_TEMP) begin
            reg_word = t;
        end else if (sel == PTR_CONF) begin
            reg_word = {c, 8'h00};
        end else if (sel == PTR_HYST) begin
            reg_word = h;
        end else begin
            reg_word = o;
        end
    endfunction
    assign cur_word = reg_word(pointer_value[1:0], temp_value, conf_value, hyst_value, over_value);

    // byte framing and protocol engine
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ST_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h00;
            ack_phase_reg <= 1'b0;
            rd_nack_reg   <= 1'b0;
            rd_second_reg <= 1'b0;
            wr_second_reg <= 1'b0;
            tx_reg        <= 8'h00;
            sda_low_reg   <= 1'b0;
            pointer_value <= PTR_RESET;                      // [R17]
            conf_value    <= CONF_RESET[7:0];
            hyst_value    <= HYST_RESET;
            over_value    <= OVER_RESET;
        end else if (timeout) begin
            state_reg   <= ST_IDLE;                          // [R19]
            sda_low_reg <= 1'b0;
        end else if (start_cond) begin
            state_reg     <= ST_ADDR;                        // [R5] [R10] [R21]
            bit_cnt_reg   <= 4'h0;
            ack_phase_reg <= 1'b0;
            sda_low_reg   <= 1'b0;
        end else if (stop_cond) begin
            state_reg   <= ST_IDLE;                          // [R8] [R10]
            sda_low_reg <= 1'b0;
        end else if (state_reg != ST_IDLE && state_reg != ST_IGN) begin
            if (scl_rise && !ack_phase_reg) begin
                shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;           // [R2]
            end else if (scl_rise && ack_phase_reg && state_reg == ST_RDATA) begin
                rd_nack_reg <= sda_sync_reg[1];              // [R13]
            end
            if (scl_fall) begin
                if (!ack_phase_reg && bit_cnt_reg == BITS_PER_BYTE) begin
                    ack_phase_reg <= 1'b1;
                    bit_cnt_reg   <= 4'h0;
                    sda_low_reg   <= 1'b0;
                    if (state_reg == ST_ADDR) begin
                        if (shift_reg[7:4] == DEV_ADDR_HIGH &&
                            shift_reg[3:1] == strap_sync_reg[5:3]) begin  // [R3]
                            sda_low_reg <= 1'b1;             // [R12]
                        end else begin
                            state_reg <= ST_IGN;
                        end
                    end else if (state_reg == ST_PTR) begin
                        if (shift_reg[7:2] == PTR_UPPER_ZERO) begin
                            pointer_value <= shift_reg;      // [R14] [R15]
                            sda_low_reg   <= 1'b1;           // [R12]
                        end else begin
                            state_reg <= ST_IGN;             // [R18]
                        end
                    end else if (state_reg == ST_WDATA) begin
                        sda_low_reg <= 1'b1;                 // [R12]
                        if (pointer_value[1:0] == PTR_CONF) begin
                            conf_value <= shift_reg;         // [R20]
                        end else if (!wr_second_reg) begin
                            if (pointer_value[1:0] == PTR_HYST) begin
                                hyst_value[15:8] <= shift_reg;
                            end else if (pointer_value[1:0] == PTR_OVER) begin
                                over_value[15:8] <= shift_reg;
                            end
                        end else begin
                            if (pointer_value[1:0] == PTR_HYST) begin
                                hyst_value[7:0] <= shift_reg;
                            end else if (pointer_value[1:0] == PTR_OVER) begin
                                over_value[7:0] <= shift_reg;
                            end
                        end
                        wr_second_reg <= ~wr_second_reg;
                    end else begin
                        sda_low_reg <= 1'b0;                 // [R11]
                    end
                end else if (ack_phase_reg) begin
                    ack_phase_reg <= 1'b0;
                    sda_low_reg   <= 1'b0;
                    if (state_reg == ST_ADDR) begin
                        wr_second_reg <= 1'b0;
                        rd_second_reg <= 1'b0;
                        if (shift_reg[0]) begin
                            state_reg   <= ST_RDATA;         // [R15]
                            tx_reg      <= cur_word[15:8];   // [R20]
                            sda_low_reg <= ~cur_word[15];
                        end else begin
                            state_reg <= ST_PTR;             // [R14]
                        end
                    end else if (state_reg == ST_PTR) begin
                        state_reg <= ST_WDATA;
                    end else if (state_reg == ST_RDATA) begin
                        if (rd_nack_reg) begin
                            state_reg <= ST_IGN;             // [R13]
                        end else begin
                            // config is one byte; word regs alternate high/low [R16] [R4]
                            rd_second_reg <= (pointer_value[1:0] == PTR_CONF) ? 1'b0 : ~rd_second_reg;
                            tx_reg      <= (rd_second_reg || pointer_value[1:0] == PTR_CONF) ?
                                           cur_word[15:8] : cur_word[7:0];
                            sda_low_reg <= ~((rd_second_reg || pointer_value[1:0] == PTR_CONF) ?
                                           cur_word[15] : cur_word[7]);
                        end
                    end
                end else if (state_reg == ST_RDATA) begin
                    tx_reg      <= {tx_reg[6:0], 1'b1};
                    sda_low_reg <= ~tx_reg[6];               // [R9] [R1]
                end
            end
        end
    end

    assign link.sda_s_out = 1'b0;
    assign link.sda_s_oe  = sda_low_reg;
    assign busy           = (state_reg != ST_IDLE);
endmodule
`default_nettype wire

/* File: test/tsense_asserts.sv */
// link checks between the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module tsense_asserts (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_m_oe,
    input wire logic sda_s_out,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_SCL_LOW_ONLY: assert property (scl_oe |-> !scl_out)
        else $error("scl driven high");
    AST_RESET_RELEASE: assert property ($fell(rst) |-> !scl_oe && !sda_m_oe && !sda_s_oe)
        else $error("bus not idle after reset");
    AST_SLAVE_SDA_STABLE: assert property (scl && $past(scl) |-> $stable(sda_s_oe) && $stable(sda_s_out))
        else $error("slave data moved with scl high");
    AST_ACK_HELD: assert property (scl && $past(scl) && $past(sda_s_oe) |-> sda_s_oe)
        else $error("slave released sda with scl high");
    AST_SCL_HIGH_TIME: assert property ($rose(scl) |=> scl [*3])
        else $error("scl high too short");
    AST_SCL_LOW_TIME: assert property ($fell(scl) |=> !scl [*3])
        else $error("scl low too short");
    AST_START_BY_MASTER: assert property ($fell(sda) && scl && $past(scl) |-> sda_m_oe && !sda_s_oe)
        else $error("start not made by master");
    AST_STOP_RELEASE: assert property ($rose(sda) && scl && $past(scl) |=> !sda_s_oe [*4])
        else $error("slave drives after stop");
    cover property (scl && sda_s_oe && !sda_s_out);
    cover property ($fell(sda) && scl && $past(scl));
    cover property ($rose(sda) && scl && $past(scl));
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// bench driving register commands through the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tsense_pkg::*;
    logic        core_clk, rst, cmd_valid, cmd_read, cmd_set_ptr, rsp_ready, cmd_ready, rsp_valid, rsp_nack, busy;
    logic [2:0]  cmd_dev, strap;
    logic [7:0]  cmd_ptr, rsp_data, conf_value, pointer_value, b;
    logic [1:0]  cmd_nbytes;
    logic [15:0] cmd_wdata, temp_value, hyst_value, over_value, mreg [4];
    int          err_count, check_count, p, i;
    tsense_link_if link ();
    tsense_master tsense_master_inst (.core_clk, .rst, .link, .cmd_valid, .cmd_ready, .cmd_read, .cmd_set_ptr,
        .cmd_dev, .cmd_ptr, .cmd_nbytes, .cmd_wdata, .rsp_valid, .rsp_ready, .rsp_data, .rsp_nack);
    tsense_slave #(.TIMEOUT_CNT(2000)) tsense_slave_inst (.core_clk, .rst, .link, .addr_select_pin_2(strap[2]),
        .addr_select_pin_1(strap[1]), .addr_select_pin_0(strap[0]), .temp_value, .conf_value, .hyst_value,
        .over_value, .pointer_value, .busy);
    tsense_asserts tsense_asserts_inst (.core_clk, .rst, .scl_out(link.scl_out), .scl_oe(link.scl_oe),
        .sda_m_oe(link.sda_m_oe), .sda_s_out(link.sda_s_out), .sda_s_oe(link.sda_s_oe), .scl(link.scl),
        .sda(link.sda));
    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        #2000000;
        err_count++;
        complete_run();
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic issue(input logic rd, input logic sp, input logic [2:0] dv, input logic [7:0] pt,
                         input logic [1:0] nb, input logic [15:0] wd);
        @(posedge core_clk);
        {cmd_valid, cmd_read, cmd_set_ptr, cmd_dev, cmd_ptr, cmd_nbytes, cmd_wdata} <= {1'h1, rd, sp, dv, pt, nb, wd};
        do @(negedge core_clk); while (cmd_ready !== 1'h1);
        @(posedge core_clk);
        cmd_valid <= 1'h0;
    endtask
    task automatic rd_byte(input int stall, output logic [7:0] d);
        repeat (stall + 1) @(posedge core_clk);
        rsp_ready <= 1'h1;
        do @(negedge core_clk); while (rsp_valid !== 1'h1);
        d = rsp_data;
        @(posedge core_clk);
        rsp_ready <= 1'h0;
    endtask
    task automatic read_reg(input logic sp, input int q, input int stall);
        if (sp) p = q;
        issue(1'h1, sp, strap, 8'(q), (p == 1) ? 2'h1 : 2'h2, 16'h0000);
        rd_byte(stall, b);
        chk("read high byte", {8'h00, mreg[p][15:8]}, {8'h00, b});
        if (p != 1) begin
            rd_byte(stall, b);
            chk("read low byte", {8'h00, mreg[p][7:0]}, {8'h00, b});
        end
    endtask
    task automatic wr_reg(input logic [2:0] dv, input logic [7:0] pt, input logic [15:0] wd, input logic ok);
        issue(1'h0, 1'h0, dv, pt, (pt == 8'h01) ? 2'h1 : 2'h2, wd);
        do @(negedge core_clk); while (cmd_ready !== 1'h1);
        chk("write nack", {15'h0000, !ok}, {15'h0000, rsp_nack});
        if (ok) begin
            mreg[pt[1:0]] = (pt == 8'h01) ? {wd[15:8], 8'h00} : wd;
            p = pt;
        end
        repeat (4) @(negedge core_clk);
        chk("slave busy", 16'h0000, {15'h0000, busy});
        chk("pointer value", 16'(p), {8'h00, pointer_value});
    endtask
    initial begin
        {cmd_valid, cmd_read, cmd_set_ptr, rsp_ready, cmd_dev, cmd_ptr, cmd_nbytes, cmd_wdata} = '0;
        rst = 1'h1;
        err_count = 0;
        check_count = 0;
        i = $urandom(32'h748A);
        strap = 3'($urandom);
        temp_value = 16'($urandom);
        mreg = '{temp_value, CONF_RESET, HYST_RESET, OVER_RESET};
        p = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        chk("pointer reset", {8'h00, PTR_RESET}, {8'h00, pointer_value});
        read_reg(1'h0, 0, 0);
        for (i = 0; i < 4; i++) read_reg(1'h1, i, $urandom_range(0, 40));
        $display("test reset reads done");
        for (i = 1; i < 4; i++) wr_reg(strap, 8'(i), 16'($urandom), 1'h1);
        chk("conf value", mreg[1], {conf_value, 8'h00});
        chk("over value", mreg[3], over_value);
        chk("hyst value", mreg[2], hyst_value);
        for (i = 0; i < 4; i++) read_reg(1'h1, i, 0);
        $display("test write readback done");
        wr_reg(strap ^ 3'h5, 8'h02, 16'h1234, 1'h0);
        read_reg(1'h0, 0, 0);
        wr_reg(strap, 8'h82, 16'h5678, 1'h0);
        read_reg(1'h0, 0, 0);
        $display("test refused transfers done");
        issue(1'h1, 1'h1, strap, 8'h03, 2'h2, 16'h0000);
        // second command waits for cmd_ready until the master finishes the first, so it runs beside the reads
        fork
            issue(1'h1, 1'h0, strap, 8'h00, 2'h2, 16'h0000);
            for (i = 0; i < 4; i++) begin
                rd_byte(i * 60, b);
                chk("stalled byte", {8'h00, i[0] ? mreg[3][7:0] : mreg[3][15:8]}, {8'h00, b});
            end
        join
        $display("test buffer stall done");
        complete_run();
    end
endmodule
`default_nettype wire
